// ===== cbtif_pkg.sv
// Package for the CAN bit-timing generator and interrupt-flag block.
// Assumes a single peripheral clock and an AXI4-Lite register slave.
package cbtif_pkg;
  // Register byte addresses (printed offsets are not all multiples of four).
  localparam logic [3:0]  CBTIF_IDX_TIMING   = 4'h4;
  localparam logic [3:0]  CBTIF_IDX_PRESCALE = 4'h6;
  localparam logic [3:0]  CBTIF_IDX_FLAGS    = 4'h8;
  localparam logic [3:0]  CBTIF_IDX_CONTROL  = 4'hc;
  localparam logic [5:0]  CBTIF_ADDR_TIMING   = {CBTIF_IDX_TIMING, 2'b00};
  localparam logic [5:0]  CBTIF_ADDR_PRESCALE = {CBTIF_IDX_PRESCALE, 2'b00};
  localparam logic [5:0]  CBTIF_ADDR_FLAGS    = {CBTIF_IDX_FLAGS, 2'b00};
  localparam logic [5:0]  CBTIF_ADDR_CONTROL  = {CBTIF_IDX_CONTROL, 2'b00};
  // Reset values.
  localparam logic [15:0] CBTIF_TIMING_RST   = 16'h0000;
  localparam logic [15:0] CBTIF_PRESCALE_RST = 16'h0000;
  localparam logic [15:0] CBTIF_FLAGS_RST    = 16'h0001;
  localparam logic [15:0] CBTIF_CONTROL_RST  = 16'h0000;
  // Field positions of the bit timing register.
  localparam int CBTIF_FSEG_LSB = 12;
  localparam int CBTIF_SSEG_LSB = 8;
  localparam int CBTIF_SJW_LSB  = 4;
  localparam int CBTIF_BSP_BIT  = 0;
  // Writable masks.
  localparam logic [15:0] CBTIF_TIMING_MASK   = 16'hf731;
  localparam logic [15:0] CBTIF_PRESCALE_MASK = 16'h00ff;
  localparam logic [15:0] CBTIF_FLAGS_W1C     = 16'hfc00;
  localparam logic [15:0] CBTIF_CONTROL_MASK  = 16'h0007;
  // Flag positions.
  localparam int CBTIF_F_CMP1  = 15;
  localparam int CBTIF_F_CMP0  = 14;
  localparam int CBTIF_F_OVR   = 13;
  localparam int CBTIF_F_SLEEP = 12;
  localparam int CBTIF_F_CMP2  = 11;
  localparam int CBTIF_F_MTX   = 10;
  // Mode codes held in the control register.
  typedef enum logic [1:0] {
    CBTIF_MODE_EVENT = 2'h0,
    CBTIF_MODE_TIME  = 2'h1,
    CBTIF_MODE_TEST  = 2'h2
  } cbtif_mode_t;
  // Bit timing states.
  typedef enum logic [2:0] {
    CBTIF_ST_SYNC = 3'b001,
    CBTIF_ST_SEG1 = 3'b010,
    CBTIF_ST_SEG2 = 3'b100
  } cbtif_state_t;
  localparam logic [1:0] CBTIF_AXI_OKAY   = 2'b00;
  localparam logic [1:0] CBTIF_AXI_SLVERR = 2'b10;
endpackage

// ===== cbtif_top.sv
// CAN bit-timing generator and interrupt flags behind an AXI4-Lite slave.
// Assumes timer, mode and frame events arrive as one-cycle pulses on CLOCK_IN.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
// Function
// - Quantum lasts 2*(prescale+1) clocks; 255 gives 512 clocks.
// - Prescaler bits 15 to 8 read zero; software writes zeros there.
// - Bit is one sync quantum plus first and second segments.
// - Each segment length is its register code plus one quantum.
// - Edges expected in sync; resync lengthens phase one or shortens phase two.
// - Sample select 1 samples three times on last three clocks of phase one.
// - Sixteen-bit flag register, cleared by writing; reset value has only bit 0.
// - Bit 15 sets on compare 1 equal cycle time; write one clears.
// - Bit 14 sets on compare 0 equal local time; write one clears.
// - Event-trigger or test mode: bit 13 sets when local timer wraps.
// - Time-trigger mode: bit 13 sets on gap-follows reference message.
// - Test mode: bit 13 sets on message error, not on overload.
// - In sleep, dominant receive level sets bit 12; write one clears.
// - Bit 11 sets on compare 2 equal cycle time; write one clears.
// - Bit 10 sets on reference message when cycle count zero, or each basic cycle when cycle limit zero.
// - Sample select 0 samples once at the end of the first segment.
// - Jump width codes 00 to 11 select 1 to 4 quanta.
module cbtif_top
  import cbtif_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLOCK_IN,
  input  wire logic        ARST_N_IN,
  // AXI4-Lite write address and data.
  input  wire logic [5:0]  AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  // AXI4-Lite write response.
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  // AXI4-Lite read.
  input  wire logic [5:0]  ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  // CAN receive line from the transceiver pin.
  input  wire logic        CAN_RX_IN,
  // Timer and frame events from the rest of the controller.
  input  wire logic        CMP1_MATCH_IN,
  input  wire logic        CMP0_MATCH_IN,
  input  wire logic        CMP2_MATCH_IN,
  input  wire logic        LOCAL_WRAP_IN,
  input  wire logic        GAP_REF_RX_IN,
  input  wire logic        MSG_ERROR_IN,
  input  wire logic        REF_MSG_DONE_IN,
  input  wire logic        BASIC_CYCLE_IN,
  input  wire logic [2:0]  CYCLE_COUNT_IN,
  input  wire logic [2:0]  CYCLE_LIMIT_IN,
  // Bit timing outputs.
  output logic             TQ_TICK_OUT,
  output logic             BIT_START_OUT,
  output logic             SAMPLE_OUT,
  output logic             RX_BIT_OUT,
  output logic             HARD_SYNC_REQ_OUT
);

  // Registers.
  logic [15:0] timing_q, prescale_q, flags_q, control_q;
  logic        aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [5:0]  awaddr_q;
  logic [15:0] wdata_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Active bit timing copy, loaded whole at bit boundaries.
  logic [3:0]  act_fseg_q;
  logic [2:0]  act_sseg_q;
  logic [1:0]  act_sjw_q;
  logic        act_bsp_q;
  logic [7:0]  act_pre_q;
  // Timing engine state.
  cbtif_state_t state_q;
  logic [8:0]  pre_cnt_q;
  logic [4:0]  seg_cnt_q;
  logic [4:0]  seg_len_q;
  logic [2:0]  samp_q;
  logic        rx_s1_q, rx_s2_q, rx_prev_q, rx_bit_q;
  logic        sample_q, tick_q, bitst_q;

  // Write channel decode.
  wire        aw_take   = AWVALID_IN && !aw_got_q;
  wire        w_take    = WVALID_IN && !w_got_q;
  wire        wr_fire   = aw_got_q && w_got_q && !bvalid_q;
  wire        lo_strobe = wdata_strobe(WSTRB_IN);
  wire        wr_timing = wr_fire && awaddr_q == CBTIF_ADDR_TIMING;
  wire        wr_pre    = wr_fire && awaddr_q == CBTIF_ADDR_PRESCALE;
  wire        wr_flags  = wr_fire && awaddr_q == CBTIF_ADDR_FLAGS;
  wire        wr_ctrl   = wr_fire && awaddr_q == CBTIF_ADDR_CONTROL;
  wire        wr_hit    = wr_timing || wr_pre || wr_flags || wr_ctrl;
  wire        ar_take   = ARVALID_IN && !rvalid_q;

  // Byte strobes are captured with the data; either low lane writes its own byte.
  logic [1:0] wstrb_q;
  function automatic logic wdata_strobe(input logic [3:0] s);
    wdata_strobe = s[0] || s[1];
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] s);
    merge = {s[1] ? nw[15:8] : old[15:8], s[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Read decode; unmapped addresses answer SLVERR with zero data.
  wire        rd_timing = ARADDR_IN == CBTIF_ADDR_TIMING;
  wire        rd_pre    = ARADDR_IN == CBTIF_ADDR_PRESCALE;
  wire        rd_flags  = ARADDR_IN == CBTIF_ADDR_FLAGS;
  wire        rd_ctrl   = ARADDR_IN == CBTIF_ADDR_CONTROL;
  wire [15:0] rd_word   = rd_timing ? timing_q :
                          rd_pre ? prescale_q :
                          rd_flags ? flags_q :
                          rd_ctrl ? control_q : 16'h0000;
  wire        rd_hit    = rd_timing || rd_pre || rd_flags || rd_ctrl;

  assign AWREADY_OUT = !aw_got_q;
  assign WREADY_OUT  = !w_got_q;
  assign ARREADY_OUT = !rvalid_q;
  assign BVALID_OUT  = bvalid_q;
  assign BRESP_OUT   = bresp_q;
  assign RVALID_OUT  = rvalid_q;
  assign RRESP_OUT   = rresp_q;
  assign RDATA_OUT   = rdata_q;

  // Write address and data may arrive in either order; each is held once taken.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q  <= 16'h0000;
      wstrb_q  <= 2'b00;
      bvalid_q <= 1'b0;
      bresp_q  <= CBTIF_AXI_OKAY;
    end else begin
      if (aw_take) begin
        aw_got_q <= 1'b1;
        awaddr_q <= AWADDR_IN;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
      if (w_take) begin
        w_got_q <= 1'b1;
        wdata_q <= WDATA_IN[15:0];
        wstrb_q <= lo_strobe ? WSTRB_IN[1:0] : 2'b00;
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? CBTIF_AXI_OKAY : CBTIF_AXI_SLVERR;
      end else if (BREADY_IN) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read answer is registered one cycle after the address is taken.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= CBTIF_AXI_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {16'h0000, rd_word};
      rresp_q  <= rd_hit ? CBTIF_AXI_OKAY : CBTIF_AXI_SLVERR;
    end else if (RREADY_IN) begin
      rvalid_q <= 1'b0;
    end
  end

  // Configuration registers; reserved bits are masked so they read zero.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      timing_q   <= CBTIF_TIMING_RST;
      prescale_q <= CBTIF_PRESCALE_RST;
      control_q  <= CBTIF_CONTROL_RST;
    end else begin
      if (wr_timing) timing_q <= merge(timing_q, wdata_q, wstrb_q) & CBTIF_TIMING_MASK;
      if (wr_pre) prescale_q <= merge(prescale_q, wdata_q, wstrb_q) & CBTIF_PRESCALE_MASK;
      if (wr_ctrl) control_q <= merge(control_q, wdata_q, wstrb_q) & CBTIF_CONTROL_MASK;
    end
  end
  // Mode and sleep come from the control register.
  wire [1:0] mode_v   = control_q[1:0];
  wire       sleep_v  = control_q[2];
  wire       m_event  = mode_v == CBTIF_MODE_EVENT;
  wire       m_time   = mode_v == CBTIF_MODE_TIME;
  wire       m_test   = mode_v == CBTIF_MODE_TEST;

  // Flag set terms; bit 0 keeps its reset value as it is served elsewhere.
  wire ovr_set = (LOCAL_WRAP_IN && (m_event || m_test))
               || (GAP_REF_RX_IN && m_time)
               || (MSG_ERROR_IN && m_test);
  wire mtx_set = (REF_MSG_DONE_IN && CYCLE_COUNT_IN == 3'h0)
               || (BASIC_CYCLE_IN && CYCLE_LIMIT_IN == 3'h0);
  wire slp_set = sleep_v && !rx_s2_q;
  logic [15:0] flag_set;
  always_comb begin
    flag_set = 16'h0000;
    flag_set[CBTIF_F_CMP1]  = CMP1_MATCH_IN;
    flag_set[CBTIF_F_CMP0]  = CMP0_MATCH_IN;
    flag_set[CBTIF_F_OVR]   = ovr_set;
    flag_set[CBTIF_F_SLEEP] = slp_set;
    flag_set[CBTIF_F_CMP2]  = CMP2_MATCH_IN;
    flag_set[CBTIF_F_MTX]   = mtx_set;
  end
  wire [15:0] flag_clr = wr_flags ? (merge(16'h0000, wdata_q, wstrb_q) & CBTIF_FLAGS_W1C)
                                  : 16'h0000;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      flags_q <= CBTIF_FLAGS_RST;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // Receive pin passes two flip-flops before anything reads it.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q   <= CAN_RX_IN;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  // Quantum divider and segment sequencing.
  wire [8:0] tq_len   = {act_pre_q, 1'b1};
  wire       tq_end   = pre_cnt_q == tq_len;
  wire       fall     = rx_prev_q && !rx_s2_q;
  wire [4:0] sjw_v    = {3'h0, act_sjw_q} + 5'h01;
  wire [4:0] seg1_len = {1'b0, act_fseg_q} + 5'h01;
  wire [4:0] seg2_len = {2'b00, act_sseg_q} + 5'h01;
  wire       seg_last = tq_end && seg_cnt_q + 5'h01 >= seg_len_q;
  wire [4:0] seg1_rem = seg_len_q - seg_cnt_q;
  wire       last3    = state_q == CBTIF_ST_SEG1 && (act_pre_q == 8'h00
                        ? (seg1_rem == 5'h01 || (seg1_rem == 5'h02 && tq_end))
                        : (seg1_rem == 5'h01 && pre_cnt_q >= tq_len - 9'h002));
  wire       one_pt   = state_q == CBTIF_ST_SEG1 && seg_last;
  wire       maj      = (samp_q[0] & samp_q[1]) | (samp_q[0] & rx_s2_q)
                        | (samp_q[1] & rx_s2_q);

  assign TQ_TICK_OUT       = tick_q;
  assign BIT_START_OUT     = bitst_q;
  assign SAMPLE_OUT        = sample_q;
  assign RX_BIT_OUT        = rx_bit_q;
  assign HARD_SYNC_REQ_OUT = 1'b0;

  // Timing state machine; edges in phase one lengthen it, in phase two shorten it.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_q    <= CBTIF_ST_SYNC;
      pre_cnt_q  <= 9'h000;
      seg_cnt_q  <= 5'h00;
      seg_len_q  <= 5'h01;
      act_fseg_q <= 4'h0;
      act_sseg_q <= 3'h0;
      act_sjw_q  <= 2'h0;
      act_bsp_q  <= 1'b0;
      act_pre_q  <= 8'h00;
      tick_q     <= 1'b0;
      bitst_q    <= 1'b0;
    end else begin
      tick_q    <= tq_end;
      bitst_q   <= 1'b0;
      pre_cnt_q <= tq_end ? 9'h000 : pre_cnt_q + 9'h001;
      case (state_q)
        CBTIF_ST_SYNC: begin
          if (tq_end) begin
            state_q   <= CBTIF_ST_SEG1;
            seg_cnt_q <= 5'h00;
            seg_len_q <= seg1_len;
          end
        end
        CBTIF_ST_SEG1: begin
          if (fall && tq_end) begin
            seg_len_q <= seg_len_q + ((seg_cnt_q < sjw_v) ? seg_cnt_q : sjw_v);
            seg_cnt_q <= seg_cnt_q + 5'h01;
          end else if (seg_last) begin
            state_q   <= CBTIF_ST_SEG2;
            seg_cnt_q <= 5'h00;
            seg_len_q <= seg2_len;
          end else if (tq_end) begin
            seg_cnt_q <= seg_cnt_q + 5'h01;
          end
        end
        CBTIF_ST_SEG2: begin
          if (seg_last || (fall && seg_len_q - seg_cnt_q <= sjw_v)) begin
            state_q    <= CBTIF_ST_SYNC;
            pre_cnt_q  <= 9'h000;
            bitst_q    <= 1'b1;
            act_fseg_q <= timing_q[CBTIF_FSEG_LSB +: 4];
            act_sseg_q <= timing_q[CBTIF_SSEG_LSB +: 3];
            act_sjw_q  <= timing_q[CBTIF_SJW_LSB +: 2];
            act_bsp_q  <= timing_q[CBTIF_BSP_BIT];
            act_pre_q  <= prescale_q[7:0];
          end else if (tq_end) begin
            seg_cnt_q <= seg_cnt_q + 5'h01;
          end
        end
        default: state_q <= CBTIF_ST_SYNC;
      endcase
    end
  end

  // Sampling: one point, or three points with a majority vote.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      samp_q   <= 3'b111;
      rx_bit_q <= 1'b1;
      sample_q <= 1'b0;
    end else begin
      sample_q <= one_pt;
      if (act_bsp_q && last3) samp_q <= {samp_q[1:0], rx_s2_q};
      if (one_pt) rx_bit_q <= act_bsp_q ? maj : rx_s2_q;
    end
  end

endmodule // cbtif_top

// ===== cbtif_monitor.sv
// Concurrent checks on the ports of the bit-timing and flag block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
module cbtif_monitor
  import cbtif_pkg::*;
(
  // Clock and reset.
  input wire logic        CLOCK_IN,
  input wire logic        ARST_N_IN,
  // Register bus handshakes.
  input wire logic        AWVALID_IN,
  input wire logic        AWREADY_OUT,
  input wire logic        WVALID_IN,
  input wire logic        WREADY_OUT,
  input wire logic [1:0]  BRESP_OUT,
  input wire logic        BVALID_OUT,
  input wire logic        BREADY_IN,
  input wire logic [5:0]  ARADDR_IN,
  input wire logic        ARVALID_IN,
  input wire logic        ARREADY_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic [1:0]  RRESP_OUT,
  input wire logic        RVALID_OUT,
  input wire logic        RREADY_IN,
  // Bit timing outputs.
  input wire logic        TQ_TICK_OUT,
  input wire logic        BIT_START_OUT,
  input wire logic        SAMPLE_OUT,
  input wire logic        RX_BIT_OUT
);
  logic [5:0] rd_addr_q;
  logic [5:0] rd_addr_d;
  default clocking mon_cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // The read address is kept so read data can be judged against its register.
  assign rd_addr_d = (ARVALID_IN && ARREADY_OUT) ? ARADDR_IN : rd_addr_q;
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) rd_addr_q <= 6'h00;
    else rd_addr_q <= rd_addr_d;
  end
  // A bit holds at least three quanta of two clocks, so boundaries never crowd.
  sequence s_no_bit5; !BIT_START_OUT [*5]; endsequence
  sequence s_no_sample5; !SAMPLE_OUT [*5]; endsequence
  sequence s_wr_taken; AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT; endsequence
  AST_TQ_SPACED: assert property (TQ_TICK_OUT |=> !TQ_TICK_OUT)
    else $error("quantum shorter than two clocks");
  AST_BIT_MIN: assert property (BIT_START_OUT |=> s_no_bit5)
    else $error("bit boundaries too close");
  AST_ONE_SAMPLE: assert property (SAMPLE_OUT |=> s_no_sample5)
    else $error("more than one sample point in a bit");
  AST_RX_AT_SAMPLE: assert property ($changed(RX_BIT_OUT) |-> SAMPLE_OUT || $past(SAMPLE_OUT))
    else $error("received bit changed away from a sample point");
  AST_RVALID_HOLD: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read answer dropped or changed");
  AST_BVALID_HOLD: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write answer dropped or changed");
  AST_WRITE_ANSWER: assert property (s_wr_taken |-> ##[1:2] BVALID_OUT)
    else $error("write response late");
  AST_READ_ANSWER: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
    else $error("read response late");
  AST_PRESCALE_HIGH: assert property (RVALID_OUT && rd_addr_q == CBTIF_ADDR_PRESCALE |-> RDATA_OUT[31:8] == 24'h000000)
    else $error("prescaler upper bits not zero");
  AST_FLAG_LOW: assert property (RVALID_OUT && rd_addr_q == CBTIF_ADDR_FLAGS |-> RDATA_OUT[9:0] == 10'h001)
    else $error("flag register low bits wrong");
  AST_SLVERR_ZERO: assert property (RVALID_OUT && RRESP_OUT == CBTIF_AXI_SLVERR |-> RDATA_OUT == 32'h00000000)
    else $error("refused read returned data");
endmodule // cbtif_monitor

bind cbtif_top cbtif_monitor i_cbtif_monitor (.CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN),
  .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT), .WVALID_IN(WVALID_IN),
  .WREADY_OUT(WREADY_OUT), .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT),
  .BREADY_IN(BREADY_IN), .ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN),
  .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT),
  .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .TQ_TICK_OUT(TQ_TICK_OUT),
  .BIT_START_OUT(BIT_START_OUT), .SAMPLE_OUT(SAMPLE_OUT), .RX_BIT_OUT(RX_BIT_OUT));

// ===== cbtif_can_node.sv
// Behavioural far-side CAN node driving the receive line.
// Assumes the controller's bit boundary pulse marks the sync quantum.
`timescale 1ns/1ns
module cbtif_can_node (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // Bit boundary, next bit value and wake-up request.
  input  wire logic bit_start_in,
  input  wire logic next_bit_in,
  input  wire logic dominant_in,
  // Receive line toward the controller.
  output logic      rx_out
);
  logic bit_q;
  // New bits launch just after a boundary so every edge falls in the sync quantum.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) bit_q <= 1'b1;
    else if (bit_start_in) bit_q <= next_bit_in;
  end
  // A forced dominant level models bus traffic while the controller sleeps.
  assign rx_out = dominant_in ? 1'b0 : bit_q;
endmodule // cbtif_can_node

// ===== test_cbtif_top.sv
// Self-checking bench: register model, bit timing counts, sampled bits and flags.
// Assumes the monitor is bound in and the CAN node model sits on the receive line.
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module test_cbtif_top;
  import cbtif_pkg::*;
  logic clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [5:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [7:0] ev = 0;
  logic [2:0] cnt = 0, lim = 0;
  logic dom = 0, nxt = 1, rx, tq, bs, smp, rxb, awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp, r;
  int miscompares = 0, num_checks = 0, n, p, flags, m, slp, e, cc, cl, drv, pend;
  int fs[4] = '{3, 15, 4, 9};
  int ss[4] = '{2, 7, 1, 4};
  cbtif_top i_cbtif_top (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .AWADDR_IN(awaddr),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awr), .WDATA_IN(wdata), .WSTRB_IN(4'h3),
    .WVALID_IN(wvalid), .WREADY_OUT(wr), .BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arr), .RDATA_OUT(rd),
    .RRESP_OUT(rresp), .RVALID_OUT(rv), .RREADY_IN(rready), .CAN_RX_IN(rx),
    .CMP1_MATCH_IN(ev[0]), .CMP0_MATCH_IN(ev[1]), .CMP2_MATCH_IN(ev[2]), .LOCAL_WRAP_IN(ev[3]),
    .GAP_REF_RX_IN(ev[4]), .MSG_ERROR_IN(ev[5]), .REF_MSG_DONE_IN(ev[6]),
    .BASIC_CYCLE_IN(ev[7]), .CYCLE_COUNT_IN(cnt), .CYCLE_LIMIT_IN(lim), .TQ_TICK_OUT(tq),
    .BIT_START_OUT(bs), .SAMPLE_OUT(smp), .RX_BIT_OUT(rxb), .HARD_SYNC_REQ_OUT());
  cbtif_can_node i_cbtif_can_node (.clk_in(clk), .arst_n_in(arst_n), .bit_start_in(bs),
    .next_bit_in(nxt), .dominant_in(dom), .rx_out(rx));
  // Clock at 20 MHz.
  initial begin
    forever #25 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Write master: handshakes are judged at the negedge, whose values hold until the next edge.
  task automatic axi_wr(input logic [5:0] a, input logic [15:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      aw = awvalid && awr;
      w = wvalid && wr;
      b = bv && bready;
      r = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask
  // Read master, same sampling discipline.
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d);
    logic ar, v;
    v = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!v) begin
      @(negedge clk);
      ar = arvalid && arr;
      v = rv && rready;
      d = rd;
      r = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (v) rready <= 1'b0;
    end
  endtask
  function automatic logic pick(int s);
    return (s == 0) ? tq : (s == 1) ? bs : smp;
  endfunction
  // Clocks from one pulse of kind a to the next pulse of kind b.
  task automatic gap(input int a, input int b, output int k);
    k = 0;
    do @(negedge clk); while (!pick(a));
    do begin @(negedge clk); k++; end while (!pick(b));
  endtask
  // Flag bit that an event should set under the given mode and counts.
  function automatic int flag_of(int ev_i, int mode, int ccount, int climit, int sleep);
    case (ev_i)
      0: return 1 << 15;
      1: return 1 << 14;
      2: return 1 << 11;
      3: return (mode != 1) ? 1 << 13 : 0;
      4: return (mode == 1) ? 1 << 13 : 0;
      5: return (mode == 2) ? 1 << 13 : 0;
      6: return (ccount == 0) ? 1 << 10 : 0;
      7: return (climit == 0) ? 1 << 10 : 0;
      default: return sleep ? 1 << 12 : 0;
    endcase
  endfunction
  // Watchdog sized well above the expected run length.
  initial begin
    #(100000 * 50);
    miscompares++;
    end_sim();
  end
  // Main sequence.
  initial begin
    logic [31:0] d;
    void'($urandom(32'hbe3e180e));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    axi_rd(CBTIF_ADDR_TIMING, d); `CHK(d, {16'h0, CBTIF_TIMING_RST})
    axi_rd(CBTIF_ADDR_PRESCALE, d); `CHK(d, 32'h00000000)
    axi_rd(CBTIF_ADDR_FLAGS, d); `CHK(d, 32'h00000001)
    axi_rd(6'h3c, d); `CHK({r, d}, {CBTIF_AXI_SLVERR, 32'h0})
    axi_wr(6'h3c, 16'hffff); `CHK(r, CBTIF_AXI_SLVERR)
    axi_wr(CBTIF_ADDR_TIMING, 16'hffff);
    axi_rd(CBTIF_ADDR_TIMING, d); `CHK(d, 32'h0000f731)
    axi_wr(CBTIF_ADDR_PRESCALE, 16'hffff);
    axi_rd(CBTIF_ADDR_PRESCALE, d); `CHK(d, 32'h000000ff)
    axi_wr(CBTIF_ADDR_TIMING, 16'h3200);
    gap(1, 0, n);
    gap(0, 0, n); `CHK(n, 512)
    // Legal bit settings only: 8 to 25 quanta, second segment at least 2, jump width within it.
    for (int i = 0; i < 4; i++) begin
      p = $urandom_range(3);
      axi_wr(CBTIF_ADDR_PRESCALE, 16'(p));
      axi_wr(CBTIF_ADDR_TIMING, 16'((fs[i] << 12) | (ss[i] << 8) | ((ss[i] > 3 ? 3 : ss[i]) << 4) | (i & 1)));
      gap(1, 1, n);
      gap(1, 1, n); `CHK(n, 2 * (p + 1) * (3 + fs[i] + ss[i]))
      gap(2, 1, n); `CHK(n, 2 * (p + 1) * (ss[i] + 1))
      drv = -1;
      pend = nxt;
      for (int j = 0; j < 8; j++) begin
        do @(negedge clk); while (!bs);
        if (drv >= 0) `CHK(rxb, 1'(drv))
        drv = pend;
        pend = $urandom_range(1);
        @(posedge clk);
        nxt <= 1'(pend);
      end
    end
    // Flag events under random modes; the line is left recessive first.
    @(posedge clk);
    nxt <= 1'b1;
    repeat (2) gap(1, 1, n);
    flags = 1;
    for (int i = 0; i < 40; i++) begin
      m = $urandom_range(2);
      slp = $urandom_range(1);
      e = $urandom_range(8);
      cc = $urandom_range(1);
      cl = $urandom_range(1);
      axi_wr(CBTIF_ADDR_CONTROL, 16'(m | (slp << 2)));
      @(posedge clk);
      cnt <= 3'(cc);
      lim <= 3'(cl);
      if (e == 8) dom <= 1'b1;
      else ev <= 8'(1 << e);
      @(posedge clk);
      ev <= 8'h00;
      repeat (3) @(posedge clk);
      dom <= 1'b0;
      repeat (4) @(posedge clk);
      flags |= flag_of(e, m, cc, cl, slp);
      axi_rd(CBTIF_ADDR_FLAGS, d); `CHK(d, 32'(flags))
      n = $urandom_range(16'hffff);
      axi_wr(CBTIF_ADDR_FLAGS, 16'(n));
      flags &= ~(n & 32'h0000fc00);
      axi_rd(CBTIF_ADDR_FLAGS, d); `CHK(d, 32'(flags))
    end
    end_sim();
  end
endmodule // test_cbtif_top
